//--- pkg/panel_pkg.sv
// Shared constants and types for the front-panel mode controller.
package panel_pkg;

   // Clock rate and the figures that timing counts derive from.
   localparam int CLK_MHZ        = 100;
   localparam int DEBOUNCE_MS    = 10;
   localparam int FLASH_MS       = 250;
   localparam int RATE_STEP_US   = 1000;
   localparam int WIDTH_STEP_US  = 10;
   localparam int DEBOUNCE_CYC   = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int FLASH_CYC      = FLASH_MS * 1000 * CLK_MHZ;
   localparam int RATE_STEP_CYC  = RATE_STEP_US * CLK_MHZ;
   localparam int WIDTH_STEP_CYC = WIDTH_STEP_US * CLK_MHZ;

   // Register byte offsets.
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] BUTTON_OFS = 8'h04;
   localparam logic [7:0] CONFIG_OFS = 8'h08;

   // Reset value of the configuration register.
   localparam logic CONFIG_RESET = 1'b0;

   // Button positions in the button vector and in the soft-press register.
   localparam int NUM_BTN       = 15;
   localparam int BTN_FREQ_LINE = 0;
   localparam int BTN_FREQ_MID  = 1;
   localparam int BTN_FREQ_TOP  = 2;
   localparam int BTN_CH_A      = 3;
   localparam int BTN_CH_B      = 4;
   localparam int BTN_SWAP      = 5;
   localparam int BTN_AUTO      = 6;
   localparam int BTN_RNG_LOW   = 7;
   localparam int BTN_RNG_MED1  = 8;
   localparam int BTN_RNG_MED2  = 9;
   localparam int BTN_RNG_HIGH  = 10;
   localparam int BTN_LOCKOUT   = 11;
   localparam int BTN_POS       = 12;
   localparam int BTN_NEG       = 13;
   localparam int BTN_STYLE     = 14;

   // Frequency button group, one-hot.
   typedef enum logic [2:0] {
      FREQ_LINE = 3'b001,
      FREQ_MID  = 3'b010,
      FREQ_TOP  = 3'b100
   } freq_sel_t;

   // Test range, one-hot.
   typedef enum logic [3:0] {
      RNG_LOW  = 4'b0001,
      RNG_MED1 = 4'b0010,
      RNG_MED2 = 4'b0100,
      RNG_HIGH = 4'b1000
   } range_t;

   // Oscillator frequency code sent to the sine generator.
   typedef enum logic [4:0] {
      OSC_50   = 5'b00001,
      OSC_60   = 5'b00010,
      OSC_200  = 5'b00100,
      OSC_400  = 5'b01000,
      OSC_2000 = 5'b10000
   } osc_code_t;

   // Indicator lamps.
   typedef struct packed {
      logic [2:0] freq;
      logic       ch_a;
      logic       ch_b;
      logic       swap;
      logic       auto_scan;
      logic [3:0] range;
      logic       lockout;
      logic       pos;
      logic       neg;
      logic       style;
   } panel_leds_t;

   // Controls for the analog test-signal circuits.
   typedef struct packed {
      osc_code_t osc;
      logic      ch_b_sel;
      range_t    range;
   } analog_ctl_t;

   // Pulse generator output stage.
   typedef struct packed {
      logic       pos_drive;
      logic       neg_drive;
      logic [7:0] level;
   } gen_out_t;

   // Status register layout, low bits of the read word.
   typedef struct packed {
      logic       style_pulse;
      logic       neg_en;
      logic       pos_en;
      logic       lockout;
      range_t     range;
      logic       auto_scan;
      logic       swap;
      logic       ch_b;
      freq_sel_t  freq;
   } status_t;

endpackage

//--- rtl/button_debouncer.sv
// Synchroniser, debouncer and press detector for a vector of panel buttons.
`timescale 1ns/1ns
`default_nettype none
module button_debouncer #(
   parameter int N   = 4,
   parameter int CYC = 1000
) (
   // Clock and reset.
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Raw button pins and one-cycle press pulses.
   input  wire logic [N-1:0] btn,
   output var  logic [N-1:0] press
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] samp;
      logic [N-1:0] stable;
      logic [N-1:0] press;
      logic [31:0]  cnt;
   } deb_t;

   deb_t deb_reg;
   deb_t deb_next;

   // A level is accepted only when two samples one period apart agree, so bounce is ignored.
   always_comb begin
      deb_next       = deb_reg;
      deb_next.s1    = btn;
      deb_next.s2    = deb_reg.s1;
      deb_next.press = '0;
      deb_next.cnt   = deb_reg.cnt + 32'h0000_0001;
      if (deb_reg.cnt >= 32'(CYC - 1)) begin
         deb_next.cnt  = 32'h0000_0000;
         deb_next.samp = deb_reg.s2;
         for (int i = 0; i < N; i++) begin
            if (deb_reg.s2[i] == deb_reg.samp[i]) begin
               deb_next.stable[i] = deb_reg.s2[i];
               deb_next.press[i]  = deb_reg.s2[i] & ~deb_reg.stable[i];
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         deb_reg <= '0;
      end else begin
         deb_reg <= deb_next;
      end
   end

   assign press = deb_reg.press;
endmodule // button_debouncer
`default_nettype wire

//--- rtl/front_panel_mode_controller.sv
// Front-panel mode controller with its APB register slave.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module front_panel_mode_controller
   import panel_pkg::*;
#(
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter int FLASH_CYCLES    = FLASH_CYC,
   parameter int RATE_CYCLES     = RATE_STEP_CYC
) (
   // Clock and reset.
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave.
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output var  logic [31:0]        prdata,
   output var  logic               pready,
   output var  logic               pslverr,
   // Panel buttons, jumpers and knobs.
   input  wire logic [NUM_BTN-1:0] btn,
   input  wire logic               line_freq_jumper,
   input  wire logic               mid_freq_jumper,
   input  wire logic [7:0]         rate_knob,
   input  wire logic [7:0]         width_knob,
   input  wire logic [7:0]         level_knob,
   // Test sine comparator, high while the sine is positive.
   input  wire logic               sine_positive,
   // Lamps, analog controls and pulse generator.
   output var  panel_leds_t        leds,
   output var  analog_ctl_t        analog,
   output var  gen_out_t           pulse_output_terminal
);
   localparam int PW = 18;

   typedef struct packed {
      logic [1:0]  jl_s;
      logic [1:0]  jm_s;
      logic [2:0]  sine_s;
      logic [7:0]  rate1;
      logic [7:0]  rate2;
      logic [7:0]  width1;
      logic [7:0]  width2;
      logic [7:0]  level1;
      logic [7:0]  level2;
      freq_sel_t   freq;
      logic        ch_b;
      logic        swap;
      logic        auto_scan;
      range_t      range;
      logic        lockout;
      logic        pos_en;
      logic        neg_en;
      logic        style_pulse;
      logic        panel_lock;
      logic [31:0] flash_cnt;
      logic        flash;
      logic        pos_act;
      logic        neg_act;
      logic [PW-1:0] pos_cnt;
      logic [PW-1:0] neg_cnt;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      panel_leds_t leds;
      analog_ctl_t analog;
      gen_out_t    gen;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic [NUM_BTN-1:0] deb_press;
   logic               tick;

   button_debouncer #(
      .N   (NUM_BTN),
      .CYC (DEBOUNCE_CYCLES)
   ) u_debounce (
      .pclk    (pclk),
      .presetn (presetn),
      .btn     (btn),
      .press   (deb_press)
   );

   rate_ticker #(
      .STEP (RATE_CYCLES)
   ) u_ticker (
      .pclk    (pclk),
      .presetn (presetn),
      .rate    (st_reg.rate2),
      .tick    (tick)
   );

   // Next range in the scan; lockout folds the top range out of the cycle.
   function automatic range_t scan_step(range_t r, logic lock);
      range_t n;
      n = RNG_LOW;
      unique case (r)
         RNG_LOW:  n = RNG_MED1;
         RNG_MED1: n = RNG_MED2;
         RNG_MED2: n = lock ? RNG_LOW : RNG_HIGH;
         RNG_HIGH: n = RNG_LOW;
         default:  n = RNG_LOW;
      endcase
      return n;
   endfunction

   logic               wr;
   logic [NUM_BTN-1:0] press;
   logic               zc_up;
   logic               zc_down;
   logic [PW-1:0]      width_cyc;
   status_t            status;

   always_comb begin
      st_next = st_reg;

      // Two-flop synchronisers for the pins.
      st_next.jl_s   = {st_reg.jl_s[0], line_freq_jumper};
      st_next.jm_s   = {st_reg.jm_s[0], mid_freq_jumper};
      st_next.sine_s = {st_reg.sine_s[1:0], sine_positive};
      st_next.rate1  = rate_knob;
      st_next.rate2  = st_reg.rate1;
      st_next.width1 = width_knob;
      st_next.width2 = st_reg.width1;
      st_next.level1 = level_knob;
      st_next.level2 = st_reg.level1;

      // A write takes effect in the access cycle in which pready is high.
      wr = psel & penable & pwrite & st_reg.pready;

      // Soft presses from software behave like panel presses, but panel_lock masks only the panel presses.
      press = st_reg.panel_lock ? '0 : deb_press;
      if (wr && paddr == BUTTON_OFS) begin
         press = press | pwdata[NUM_BTN-1:0];
      end
      if (wr && paddr == CONFIG_OFS) begin
         st_next.panel_lock = pwdata[0];
      end

      // Frequency group.
      if (press[BTN_FREQ_LINE]) begin
         st_next.freq = FREQ_LINE;
      end else if (press[BTN_FREQ_MID]) begin
         st_next.freq = FREQ_MID;
      end else if (press[BTN_FREQ_TOP]) begin
         st_next.freq = FREQ_TOP;
      end

      // Channel selection.
      if (press[BTN_CH_A]) begin
         st_next.ch_b = 1'b0;
         st_next.swap = 1'b0;
      end else if (press[BTN_CH_B]) begin
         st_next.ch_b = 1'b1;
         st_next.swap = 1'b0;
      end else if (press[BTN_SWAP]) begin
         st_next.swap = 1'b1;
      end

      // Lockout toggles; engaging it while high is selected drops to med2.
      if (press[BTN_LOCKOUT]) begin
         st_next.lockout = ~st_reg.lockout;
         if (!st_reg.lockout && st_reg.range == RNG_HIGH) begin
            st_next.range = RNG_MED2;
         end
      end

      // Range buttons win over auto and cancel it.
      if (press[BTN_RNG_LOW]) begin
         st_next.range     = RNG_LOW;
         st_next.auto_scan = 1'b0;
      end else if (press[BTN_RNG_MED1]) begin
         st_next.range     = RNG_MED1;
         st_next.auto_scan = 1'b0;
      end else if (press[BTN_RNG_MED2]) begin
         st_next.range     = RNG_MED2;
         st_next.auto_scan = 1'b0;
      end else if (press[BTN_RNG_HIGH]) begin
         st_next.range     = st_next.lockout ? RNG_MED2 : RNG_HIGH;
         st_next.auto_scan = 1'b0;
      end else if (press[BTN_AUTO]) begin
         st_next.auto_scan = 1'b1;
      end

      // Sequencing. In the combined mode the channel alternates on every tick that meets no channel, auto
      // or range press, and the range advances each time the channel returns to A.
      if (tick && !(|press[BTN_RNG_HIGH:BTN_CH_A])) begin
         if (st_reg.swap) begin
            st_next.ch_b = ~st_reg.ch_b;
         end
         if (st_reg.auto_scan && (!st_reg.swap || st_reg.ch_b)) begin
            st_next.range = scan_step(st_reg.range, st_reg.lockout);
         end
      end
      if (st_next.lockout && st_next.range == RNG_HIGH) begin
         st_next.range = RNG_MED2;
      end

      // Polarity and output style.
      if (press[BTN_POS]) begin
         if (!st_reg.style_pulse && (st_reg.pos_en ^ st_reg.neg_en)) begin
            st_next.pos_en = ~st_reg.pos_en;
            st_next.neg_en = ~st_reg.neg_en;
         end else begin
            st_next.pos_en = ~st_reg.pos_en;
         end
      end else if (press[BTN_NEG]) begin
         // In DC mode a second polarity would be illegal, so the press is ignored.
         if (st_reg.style_pulse || !st_reg.pos_en) begin
            st_next.neg_en = ~st_reg.neg_en;
         end
      end
      if (press[BTN_STYLE]) begin
         st_next.style_pulse = ~st_reg.style_pulse;
         if (st_reg.style_pulse && st_reg.pos_en && st_reg.neg_en) begin
            st_next.neg_en = 1'b0;
         end
      end

      // Lamp flasher for pulse mode.
      st_next.flash_cnt = st_reg.flash_cnt + 32'h0000_0001;
      if (st_reg.flash_cnt >= 32'(FLASH_CYCLES - 1)) begin
         st_next.flash_cnt = 32'h0000_0000;
         st_next.flash     = ~st_reg.flash;
      end

      // Zero crossings from the synchronised comparator.
      zc_up     = st_reg.sine_s[1] & ~st_reg.sine_s[2];
      zc_down   = ~st_reg.sine_s[1] & st_reg.sine_s[2];
      width_cyc = PW'(st_reg.width2) * PW'(WIDTH_STEP_CYC);

      // Positive pulse: starts at the rising crossing, stops on width or the falling one.
      if (st_reg.pos_act) begin
         st_next.pos_cnt = st_reg.pos_cnt - {{(PW-1){1'b0}}, 1'b1};
         if (st_reg.pos_cnt <= {{(PW-1){1'b0}}, 1'b1} || zc_down) begin
            st_next.pos_act = 1'b0;
         end
      end
      if (zc_up && st_reg.pos_en && width_cyc != '0) begin
         st_next.pos_act = 1'b1;
         st_next.pos_cnt = width_cyc;
      end

      // Negative pulse: mirror image on the falling crossing.
      if (st_reg.neg_act) begin
         st_next.neg_cnt = st_reg.neg_cnt - {{(PW-1){1'b0}}, 1'b1};
         if (st_reg.neg_cnt <= {{(PW-1){1'b0}}, 1'b1} || zc_up) begin
            st_next.neg_act = 1'b0;
         end
      end
      if (zc_down && st_reg.neg_en && width_cyc != '0) begin
         st_next.neg_act = 1'b1;
         st_next.neg_cnt = width_cyc;
      end

      // Generator stage follows the new state.
      if (st_next.style_pulse) begin
         st_next.gen.pos_drive = st_next.pos_act & st_next.pos_en;
         st_next.gen.neg_drive = st_next.neg_act & st_next.neg_en;
      end else begin
         st_next.gen.pos_drive = st_next.pos_en;
         st_next.gen.neg_drive = st_next.neg_en;
      end
      st_next.gen.level = (st_next.pos_en | st_next.neg_en) ? st_reg.level2 : 8'h00;

      // Oscillator code from the button group and the jumpers.
      unique case (st_next.freq)
         FREQ_LINE: st_next.analog.osc = st_reg.jl_s[1] ? OSC_60 : OSC_50;
         FREQ_MID:  st_next.analog.osc = st_reg.jm_s[1] ? OSC_400 : OSC_200;
         FREQ_TOP:  st_next.analog.osc = OSC_2000;
         default:   st_next.analog.osc = OSC_2000;
      endcase
      st_next.analog.ch_b_sel = st_next.ch_b;
      st_next.analog.range    = st_next.range;

      // Lamps.
      st_next.leds.freq      = st_next.freq;
      st_next.leds.ch_a      = ~st_next.ch_b;
      st_next.leds.ch_b      = st_next.ch_b;
      st_next.leds.swap      = st_next.swap;
      st_next.leds.auto_scan = st_next.auto_scan;
      st_next.leds.range     = st_next.range;
      st_next.leds.lockout   = st_next.lockout;
      st_next.leds.pos       = st_next.pos_en;
      st_next.leds.neg       = st_next.neg_en;
      st_next.leds.style     = st_next.style_pulse ? st_next.flash : 1'b1;

      // Register read view.
      status.style_pulse = st_reg.style_pulse;
      status.neg_en      = st_reg.neg_en;
      status.pos_en      = st_reg.pos_en;
      status.lockout     = st_reg.lockout;
      status.range       = st_reg.range;
      status.auto_scan   = st_reg.auto_scan;
      status.swap        = st_reg.swap;
      status.ch_b        = st_reg.ch_b;
      status.freq        = st_reg.freq;

      // APB: the answer is prepared in the setup cycle and given in the first
      // access cycle, so every transfer completes with no wait state.
      st_next.pready  = 1'b0;
      if (psel && !penable) begin
         st_next.pready  = 1'b1;
         st_next.pslverr = 1'b0;
         st_next.prdata  = 32'h0000_0000;
         unique case (paddr)
            STATUS_OFS: st_next.prdata = 32'(status);
            BUTTON_OFS: st_next.prdata = 32'h0000_0000;
            CONFIG_OFS: st_next.prdata = {31'h0000_0000, st_reg.panel_lock};
            default:    st_next.pslverr = 1'b1;
         endcase
      end else if (!psel) begin
         st_next.pslverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg                 <= '0;
         st_reg.freq            <= FREQ_LINE;
         st_reg.range           <= RNG_LOW;
         st_reg.panel_lock      <= CONFIG_RESET;
         st_reg.analog.osc      <= OSC_50;
         st_reg.analog.range    <= RNG_LOW;
         st_reg.leds.freq       <= FREQ_LINE;
         st_reg.leds.ch_a       <= 1'b1;
         st_reg.leds.range      <= RNG_LOW;
         st_reg.leds.style      <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata                = st_reg.prdata;
   assign pready                = st_reg.pready;
   assign pslverr               = st_reg.pslverr;
   assign leds                  = st_reg.leds;
   assign analog                = st_reg.analog;
   assign pulse_output_terminal = st_reg.gen;
endmodule // front_panel_mode_controller
`default_nettype wire

//--- rtl/rate_ticker.sv
// Sequencing tick whose rate rises with the rate knob value.
`timescale 1ns/1ns
`default_nettype none
module rate_ticker #(
   parameter int STEP = 100
) (
   // Clock and reset.
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Knob value and tick pulse.
   input  wire logic [7:0] rate,
   output var  logic       tick
);
   typedef struct packed {
      logic [31:0] pre;
      logic [7:0]  units;
      logic        tick;
   } tick_t;

   tick_t tk_reg;
   tick_t tk_next;

   // Period is (256 - rate) steps, so turning the knob up shortens it.
   always_comb begin
      tk_next      = tk_reg;
      tk_next.tick = 1'b0;
      tk_next.pre  = tk_reg.pre + 32'h0000_0001;
      if (tk_reg.pre >= 32'(STEP - 1)) begin
         tk_next.pre   = 32'h0000_0000;
         tk_next.units = tk_reg.units + 8'h01;
         if (tk_reg.units >= ~rate) begin
            tk_next.units = 8'h00;
            tk_next.tick  = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tk_reg <= '0;
      end else begin
         tk_reg <= tk_next;
      end
   end

   assign tick = tk_reg.tick;
endmodule // rate_ticker
`default_nettype wire

//--- sim/front_panel_mode_controller_tb.sv
// Self-checking bench for the front-panel mode controller.
`timescale 1ns/1ns
`default_nettype none
module front_panel_mode_controller_tb;
   import panel_pkg::*;
   typedef struct {int b; logic [13:0] v;} row_t;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic               line_freq_jumper, mid_freq_jumper, sine_run, sine_positive;
   logic [7:0]         paddr, rate_knob, width_knob, level_knob;
   logic [31:0]        pwdata, prdata, rd;
   logic [NUM_BTN-1:0] btn;
   logic [4:0]         seen;
   logic [13:0]        mask;
   panel_leds_t        leds;
   analog_ctl_t        analog;
   gen_out_t           pulse_output_terminal;
   int                 fail_count, checked, n;
   row_t rows[21] = '{'{1,14'h0042}, '{2,14'h0044}, '{0,14'h0041}, '{5,14'h0051},
      '{4,14'h0049}, '{3,14'h0041}, '{6,14'h0021}, '{10,14'h0201}, '{11,14'h0501},
      '{11,14'h0101}, '{14,14'h2101}, '{12,14'h2901}, '{12,14'h2101}, '{13,14'h3101},
      '{13,14'h2101}, '{12,14'h2901}, '{13,14'h3901}, '{14,14'h0901}, '{12,14'h1101},
      '{12,14'h0901}, '{13,14'h0901}};
   front_panel_mode_controller #(.DEBOUNCE_CYCLES(4), .FLASH_CYCLES(8), .RATE_CYCLES(2)) dut (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
      .btn, .line_freq_jumper, .mid_freq_jumper, .rate_knob, .width_knob, .level_knob,
      .sine_positive, .leds, .analog, .pulse_output_terminal);
   sine_comparator_model sine (.pclk, .run(sine_run), .sine_positive);
   task automatic final_report;
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic press(input int b);
      apb(1'b1, BUTTON_OFS, 32'h1 << b);
      repeat (2) @(posedge pclk);
   endtask
   task automatic status(input logic [13:0] m, input logic [13:0] v);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd & m, v);
   endtask
   task automatic scan(input int c);
      seen = '0;
      repeat (c) begin
         @(posedge pclk);
         seen |= {leds.ch_b, leds.range};
      end
   endtask
   task automatic wait_drive(input logic neg);
      n = 0;
      while (pulse_output_terminal[9 - neg] !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   initial begin
      repeat (30000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, btn, sine_run} = '0;
      {line_freq_jumper, mid_freq_jumper, rate_knob, width_knob} = 18'h0_0001;
      level_knob = 8'h5A;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(leds, 15'h1811);
      chk(pulse_output_terminal, 32'h0);
      status(14'h3FFF, 14'h0041);
      foreach (rows[i]) begin
         press(rows[i].b);
         mask = rows[i].b == 5 ? 14'h3FF7 : rows[i].b == 6 ? 14'h3C3F : 14'h3FFF;
         status(mask, rows[i].v);
      end
      for (int j = 0; j < 2; j++) begin
         {line_freq_jumper, mid_freq_jumper} <= {2{j[0]}};
         repeat (4) @(posedge pclk);
         press(BTN_FREQ_MID);
         chk(analog.osc, j ? OSC_400 : OSC_200);
         press(BTN_FREQ_LINE);
         chk(analog.osc, j ? OSC_60 : OSC_50);
      end
      // Short glitches ahead of the real press must not count as presses.
      repeat (2) begin
         btn[BTN_POS] <= 1'b1;
         @(posedge pclk);
         btn[BTN_POS] <= 1'b0;
         @(posedge pclk);
      end
      btn[BTN_POS] <= 1'b1;
      repeat (30) @(posedge pclk);
      btn[BTN_POS] <= 1'b0;
      repeat (30) @(posedge pclk);
      status(14'h3FFF, 14'h1101);
      rate_knob <= 8'hFF;
      press(BTN_LOCKOUT);
      press(BTN_AUTO);
      scan(40);
      chk(seen, 5'h07);
      press(BTN_LOCKOUT);
      scan(40);
      chk(seen, 5'h0F);
      press(BTN_SWAP);
      scan(60);
      chk(seen, 5'h1F);
      press(BTN_CH_A);
      press(BTN_RNG_LOW);
      press(BTN_STYLE);
      seen = '0;
      repeat (20) begin
         @(posedge pclk);
         seen[leds.style] = 1'b1;
      end
      chk(seen, 5'h03);
      press(BTN_POS);
      sine_run <= 1'b1;
      wait_drive(1'b0);
      chk(pulse_output_terminal.pos_drive, 1'b1);
      chk(pulse_output_terminal.level, level_knob);
      wait_drive(1'b1);
      chk(pulse_output_terminal.neg_drive, 1'b1);
      chk(pulse_output_terminal.pos_drive, 1'b0);
      sine_run <= 1'b0;
      press(BTN_POS);
      press(BTN_NEG);
      repeat (5) @(posedge pclk);
      chk(pulse_output_terminal, 32'h0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      // Panel lock: a physical press is ignored, and status writes never land.
      apb(1'b1, CONFIG_OFS, 32'h0000_0001);
      apb(1'b0, CONFIG_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      btn[BTN_AUTO] <= 1'b1;
      repeat (30) @(posedge pclk);
      btn[BTN_AUTO] <= 1'b0;
      repeat (30) @(posedge pclk);
      apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
      status(14'h3FFF, 14'h2041);
      // A reset in mid-run must restore the power-on selection and unlock the panel.
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(leds, 32'h0000_1811);
      status(14'h3FFF, 14'h0041);
      apb(1'b0, CONFIG_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      final_report();
   end
endmodule // front_panel_mode_controller_tb
bind front_panel_mode_controller panel_props u_props (.pclk, .presetn, .psel, .penable,
   .pready, .width_knob, .sine_positive, .leds, .analog, .pulse_output_terminal);
`default_nettype wire

//--- sim/panel_props.sv
// Port assertions for the front-panel mode controller.
`timescale 1ns/1ns
`default_nettype none
module panel_props
   import panel_pkg::*;
(
   // Clock, reset and bus handshake.
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   // Knob and comparator.
   input wire logic [7:0]  width_knob,
   input wire logic        sine_positive,
   // Lamps and outputs.
   input wire panel_leds_t leds,
   input wire analog_ctl_t analog,
   input wire gen_out_t    pulse_output_terminal
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_bus_ready: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   a_freq_onehot: assert property ($onehot(leds.freq))
      else $error("frequency lamps not one-hot");
   a_top_freq: assert property (leds.freq[2] ##1 leds.freq[2] |-> analog.osc == OSC_2000)
      else $error("top button not 2000");
   a_range_onehot: assert property ($onehot(leds.range))
      else $error("range lamps not one-hot");
   a_lock_skip: assert property (leds.lockout ##1 leds.lockout |-> !leds.range[3])
      else $error("high range under lockout");
   a_one_channel: assert property ($onehot({leds.ch_a, leds.ch_b}))
      else $error("channel lamps not exclusive");
   a_no_both: assert property (
      !(pulse_output_terminal.pos_drive && pulse_output_terminal.neg_drive))
      else $error("both polarities driven");
   a_off_zero: assert property (
      (!leds.pos && !leds.neg) [*3] |-> pulse_output_terminal == '0)
      else $error("output not zero");
   a_pos_edge: assert property ($rose(sine_positive) && leds.pos && width_knob != 0
      |-> ##[2:4] pulse_output_terminal.pos_drive)
      else $error("positive pulse late");
   a_neg_edge: assert property ($fell(sine_positive) && leds.neg && width_knob != 0
      |-> ##[2:4] pulse_output_terminal.neg_drive)
      else $error("negative pulse late");
endmodule // panel_props
`default_nettype wire

//--- sim/sine_comparator_model.sv
// Test sine comparator model standing in for the analog oscillator.
`timescale 1ns/1ns
`default_nettype none
module sine_comparator_model #(
   parameter int HALF = 60
) (
   // Clock and run control.
   input  wire logic pclk,
   input  wire logic run,
   // High while the sine is positive.
   output wire logic sine_positive
);
   int   cnt = 0;
   logic s   = 1'b0;
   assign sine_positive = s;
   // Held still when idle, so crossings never meet polarity presses.
   always @(posedge pclk) begin
      if (!run) begin
         cnt <= 0;
         s <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         s <= !s;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule // sine_comparator_model
`default_nettype wire
